/* bench/sense_model.sv */
`timescale 1ns/1ps
module sense_model (
  input  wire logic                   ref_clk,
  input  wire seq_pkg::analog_flags_t flagCmd,
  input  wire seq_pkg::fast_faults_t  fastCmd,
  output seq_pkg::analog_flags_t      analogFlags,
  output seq_pkg::fast_faults_t       fastFaults
);
  // Comparators settle off the clock grid
  initial analogFlags = '0;
  always @(flagCmd) analogFlags <= #1.3 flagCmd;
  // Generator passes fast faults on the shared clock
  initial fastFaults = '0;
  always @(posedge ref_clk) fastFaults <= fastCmd;
endmodule : sense_model

/* bench/seq_monitor.sv */
`timescale 1ns/1ps
module seq_monitor #(
  parameter int unsigned WAKE_CYCLES   = 20,
  parameter int unsigned LOWPWR_CYCLES = 40,
  parameter int unsigned PAUSE_CYCLES  = 30
) (
  input wire logic                   ref_clk,
  input wire logic                   srst,
  input wire seq_pkg::analog_flags_t analogFlags,
  input wire seq_pkg::fast_faults_t  fastFaults,
  input wire logic                   generatorEnable,
  input wire logic                   regulatedSupplyEnable,
  input wire logic                   softStartEnable,
  input wire logic                   hvSourceEnable,
  input wire logic                   lowSideOn,
  input wire logic [2:0]             stateCode
);
  logic [2:0]  prevState;
  logic [31:0] dwell;
  wire  [3:0]  en;
  assign en = {generatorEnable, regulatedSupplyEnable, softStartEnable,
               hvSourceEnable};
  // Cycles in the current state, still valid at the exit edge
  always_ff @(posedge ref_clk) begin
    prevState <= stateCode;
    dwell     <= (srst || stateCode != prevState) ? 32'h1 : dwell + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_start_enables: assert property (
    stateCode <= 3'h1 |-> en == 4'h1) else $error("start enables wrong");
  a_supply_enables: assert property (
    stateCode inside {[3'h2:3'h4]} |-> en == 4'h4)
    else $error("supply enables wrong");
  a_run_enables: assert property (
    stateCode inside {3'h5, 3'h6} |-> en == 4'he)
    else $error("run enables wrong");
  a_fault_enables: assert property (
    stateCode == 3'h7 |-> en == 4'h0) else $error("fault enables wrong");
  a_low_side: assert property (
    lowSideOn == (stateCode == 3'h4)) else $error("low side wrong");
  a_ready_exit: assert property (
    stateCode == 3'h1 && prevState == 3'h0
    |-> $past(analogFlags.systemReady, 2)) else $error("left without ready");
  a_wake_dwell: assert property (
    stateCode == 3'h4 && prevState == 3'h3 |-> dwell >= WAKE_CYCLES)
    else $error("wake-up too short");
  a_fast_fault: assert property (
    stateCode inside {[3'h3:3'h6]} && fastFaults != 2'h0
    |=> stateCode == 3'h7) else $error("fast fault missed");
  a_lowpwr_limit: assert property (
    stateCode == 3'h6 && prevState == 3'h6 |-> dwell <= LOWPWR_CYCLES + 1)
    else $error("light-load too long");
  a_pause_bound: assert property (
    stateCode == 3'h7 && prevState == 3'h7 |-> dwell <= PAUSE_CYCLES + 1)
    else $error("pause too long");
  a_pause_exit: assert property (
    prevState == 3'h7 && stateCode != 3'h7
    |-> stateCode == 3'h1 && dwell >= PAUSE_CYCLES)
    else $error("pause exit wrong");
endmodule : seq_monitor

bind system_state_fault_sequencer seq_monitor #(
  .WAKE_CYCLES(WAKE_CYCLES), .LOWPWR_CYCLES(LOWPWR_CYCLES),
  .PAUSE_CYCLES(PAUSE_CYCLES)
) i_seq_monitor (
  .ref_clk(ref_clk), .srst(srst), .analogFlags(analogFlags),
  .fastFaults(fastFaults), .generatorEnable(generatorEnable),
  .regulatedSupplyEnable(regulatedSupplyEnable),
  .softStartEnable(softStartEnable), .hvSourceEnable(hvSourceEnable),
  .lowSideOn(lowSideOn), .stateCode(stateCode)
);

/* bench/test_system_state_fault_sequencer.sv */
`timescale 1ns/1ps
module test_system_state_fault_sequencer;
  localparam int W = 20;
  localparam int L = 40;
  localparam int P = 30;
  localparam int S = 10;
  localparam int G = 15;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] q;
    logic        e;
  } row_t;
  row_t rows [8] = '{
    '{1'b0, seq_pkg::ADDR_CTRL, 32'h0, 32'h0, 1'b0},
    '{1'b0, seq_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b0, seq_pkg::ADDR_INT_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b0, seq_pkg::ADDR_INT_MASK, 32'h0, 32'h0, 1'b0},
    '{1'b1, seq_pkg::ADDR_STATUS, 32'hffff_ffff, 32'h0, 1'b0},
    '{1'b0, seq_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h10, 32'h1, 32'h0, 1'b1},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}};
  // Fault causes as {analog bits, fast bits} and least reaction time
  logic [12:0] fr [8] = '{13'h010, 13'h008, 13'h004, 13'h040, 13'h080,
                          13'h100, 13'h002, 13'h001};
  int          fLo [8] = '{1, S, G, 1, 1, 1, 1, 1};
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, e, irq;
  logic generatorEnable, regulatedSupplyEnable, softStartEnable;
  logic hvSourceEnable, lowSideOn;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [2:0]  stateCode;
  seq_pkg::analog_flags_t flagCmd, analogFlags;
  seq_pkg::fast_faults_t  fastCmd, fastFaults;
  int n_mismatch, num_checks, n, i;

  system_state_fault_sequencer #(.WAKE_CYCLES(W), .LOWPWR_CYCLES(L),
    .PAUSE_CYCLES(P), .OCP_SHORT_CYCLES(S), .OCP_LONG_CYCLES(G)
  ) i_system_state_fault_sequencer (.ref_clk(ref_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .analogFlags(analogFlags), .fastFaults(fastFaults),
    .generatorEnable(generatorEnable),
    .regulatedSupplyEnable(regulatedSupplyEnable),
    .softStartEnable(softStartEnable), .hvSourceEnable(hvSourceEnable),
    .lowSideOn(lowSideOn), .stateCode(stateCode), .irq(irq));
  sense_model i_sense_model (.ref_clk(ref_clk), .flagCmd(flagCmd),
    .fastCmd(fastCmd), .analogFlags(analogFlags), .fastFaults(fastFaults));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task chk(input string s, input logic [31:0] x, input logic [31:0] y);
    num_checks++;
    if (x !== y) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, x, y);
    end
  endtask : chk

  task chkS(input logic [2:0] s);
    chk("stateCode", {29'h0, s}, {29'h0, stateCode});
  endtask : chkS

  task waitS(input logic [2:0] s, input int lim, output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (stateCode !== s && c < lim);
    if (stateCode !== s) begin
      chkS(s);
      test_done();
    end
  endtask : waitS

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready", 32'h1, 32'h0);
      test_done();
    end
  endtask : apb

  initial begin
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    flagCmd = '0;
    fastCmd = '0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("prdata", rows[i].q, q);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, e});
    end
    flagCmd.startSwitchingFlag <= 1'b1;
    flagCmd.supplyRestartFlag <= 1'b1;
    flagCmd.bulkStartFlag <= 1'b1;
    flagCmd.belowBurstThresholdFlag <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chkS(3'h0);
    flagCmd.systemReady <= 1'b1;
    waitS(3'h1, 10, n);
    repeat (20) @(posedge ref_clk);
    chkS(3'h1);
    apb(1'b0, seq_pkg::ADDR_INT_STATUS, 32'h0);
    chk("intStatus", 32'h2, q);
    apb(1'b1, seq_pkg::ADDR_INT_MASK, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, seq_pkg::ADDR_INT_STATUS, 32'h2);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    flagCmd.supplyRestartFlag <= 1'b0;
    waitS(3'h2, 10, n);
    waitS(3'h3, 10, n);
    repeat (40) @(posedge ref_clk);
    chkS(3'h3);
    flagCmd.supplyRestartFlag <= 1'b1;
    waitS(3'h1, 10, n);
    flagCmd.supplyRestartFlag <= 1'b0;
    flagCmd.belowBurstThresholdFlag <= 1'b0;
    waitS(3'h3, 20, n);
    waitS(3'h4, W + 4, n);
    chk("wakeTime", 32'h1, {31'h0, n >= W && n <= W + 2});
    waitS(3'h5, seq_pkg::BOOT_CYCLES + 4, n);
    chk("bootTime", 32'h1, {31'h0, n >= seq_pkg::BOOT_CYCLES});
    flagCmd.belowBurstThresholdFlag <= 1'b1;
    waitS(3'h6, 10, n);
    flagCmd.belowBurstThresholdFlag <= 1'b0;
    waitS(3'h5, 10, n);
    flagCmd.belowBurstThresholdFlag <= 1'b1;
    waitS(3'h6, 10, n);
    waitS(3'h7, L + 4, n);
    chk("lowPwrTime", 32'h1, {31'h0, n >= L && n <= L + 2});
    flagCmd.belowBurstThresholdFlag <= 1'b0;
    apb(1'b0, seq_pkg::ADDR_INT_STATUS, 32'h0);
    chk("intStatus", 32'hf, q);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, seq_pkg::ADDR_INT_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, seq_pkg::ADDR_INT_STATUS, 32'hf);
    apb(1'b0, seq_pkg::ADDR_INT_STATUS, 32'h0);
    chk("intStatus", 32'h0, q);
    waitS(3'h1, P + 3, n);
    for (i = 0; i < 8; i++) begin
      waitS(3'h5, W + 600, n);
      flagCmd <= flagCmd | seq_pkg::analog_flags_t'(fr[i][12:2]);
      fastCmd <= seq_pkg::fast_faults_t'(fr[i][1:0]);
      waitS(3'h7, fLo[i] + 8, n);
      chk("faultTime", 32'h1, {31'h0, n >= fLo[i]});
      flagCmd <= flagCmd & ~seq_pkg::analog_flags_t'(fr[i][12:2]);
      fastCmd <= '0;
      waitS(3'h1, P + 3, n);
      chk("pauseTime", 32'h1, {31'h0, n >= P});
    end
    waitS(3'h5, W + 600, n);
    apb(1'b0, seq_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h0006_8005, q);
    apb(1'b1, seq_pkg::ADDR_CTRL, 32'h1);
    waitS(3'h7, 8, n);
    apb(1'b1, seq_pkg::ADDR_CTRL, 32'h0);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chkS(3'h0);
    chk("hvSourceEnable", 32'h1, {31'h0, hvSourceEnable});
    srst <= 1'b0;
    flagCmd.overTemperatureFault <= 1'b1;
    waitS(3'h7, 10, n);
    test_done();
  end
endmodule : test_system_state_fault_sequencer

/* shared/seq_pkg.sv */
package seq_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS     = 4;
  localparam int WAKE_TIME_US      = 150;
  localparam int LOWPWR_LIMIT_MS   = 200;
  localparam int PAUSE_TIME_S      = 1;
  localparam int OCP_SHORT_MS      = 2;
  localparam int OCP_LONG_MS       = 50;
  localparam int BOOT_CHARGE_NS    = 2000;

  localparam int WAKE_CYCLES       =
    (WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOWPWR_CYCLES     =
    (LOWPWR_LIMIT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAUSE_CYCLES      =
    (PAUSE_TIME_S * 1000000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCP_SHORT_CYCLES  =
    (OCP_SHORT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCP_LONG_CYCLES   =
    (OCP_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOOT_CYCLES       =
    (BOOT_CHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int TIMER_W           = 28;
  localparam int OCP_W             = 24;
  localparam int SYNC_STAGES       = 2;

  // Register map (byte addresses)
  localparam int ADDR_W            = 8;
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK   = 8'h0c;

  // Field positions
  localparam int CTRL_SW_FAULT     = 0;
  localparam int STATUS_STATE_LSB  = 0;
  localparam int STATUS_FLAGS_LSB  = 8;
  localparam int STATUS_OCP_SHORT  = 20;
  localparam int STATUS_OCP_LONG   = 21;
  localparam int STATUS_FAST_LSB   = 22;
  localparam int INT_FAULT         = 0;
  localparam int INT_RESTART       = 1;
  localparam int INT_RUN           = 2;
  localparam int INT_LOWPWR        = 3;
  localparam int INT_W             = 4;

  // Reset values
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
  localparam logic [3:0]  INT_MASK_RESET = 4'h0;

  typedef enum logic [2:0] {
    POWER_ON_START_STATE,
    HV_SOURCE_ON_STATE,
    HV_SOURCE_OFF_STATE,
    ANALOG_WAKEUP_STATE,
    BOOT_CHARGE_STATE,
    NORMAL_RUN_STATE,
    LOW_POWER_RUN_STATE,
    FAULT_STATE
  } seq_state_t;

  // Comparator and detector flags, all asynchronous to ref_clk
  typedef struct packed {
    logic systemReady;
    logic startSwitchingFlag;
    logic supplyRestartFlag;
    logic bulkStartFlag;
    logic bulkStopFlag;
    logic bulkOvervoltageFlag;
    logic regulatedSupplyUndervoltage;
    logic belowBurstThresholdFlag;
    logic overTemperatureFault;
    logic avgOvercurrentShortRaw;
    logic avgOvercurrentLongRaw;
  } analog_flags_t;

  localparam int FLAG_W = $bits(analog_flags_t);

  // Fast faults from the waveform generator, same clock
  typedef struct packed {
    logic outputOvervoltageFault;
    logic peakOvercurrentFault;
  } fast_faults_t;

  typedef struct packed {
    logic generatorEnable;
    logic regulatedSupplyEnable;
    logic softStartEnable;
    logic hvSourceEnable;
    logic lowSideOn;
  } enables_t;

endpackage : seq_pkg

/* verilog/flag_sync.sv */
`timescale 1ns/1ps
module flag_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1Reg;
  logic [W-1:0] stage2Reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          stage1Reg[i] <= 1'b0;
          stage2Reg[i] <= 1'b0;
        end else begin
          stage1Reg[i] <= din[i];
          stage2Reg[i] <= stage1Reg[i];
        end
      end
    end
  endgenerate

  assign dout = stage2Reg;

endmodule : flag_sync

/* verilog/system_state_fault_sequencer.sv */
// Behaviour
// - Reset enters power-on start: source enable on, other enables off.
// - Power-on start is left when system ready (trim load done), or to fault on over-temperature.
// - Source-on state: source enable on, generator, supply, soft start off.
// - Start-switching 1 and restart 0 go source-off: source off, supply on.
// - Bulk start and no bulk faults enter wake-up, held there 150us.
// - Wake-up exit also needs below-burst flag 0 with the same bulk terms.
// - Boot charge drives low side on for fixed time, leaves when done.
// - Run state: generator, supply, soft start on; source enable off.
// - Below-burst 1 enters low_power_run_state, 0 returns; enables as run.
// - Below-burst held beyond 200ms in low_power_run_state causes a fault.
// - Fault state drops all enables, waits 1s, then restarts sequence.
// - Listed faults end active states; start-up honours temperature, bulk OV.
// - Average overcurrent faults qualified by 2ms and 50ms timers.
// - Overvoltage and peak overcurrent arrive pre-processed as fast faults.
`timescale 1ns/1ps
module system_state_fault_sequencer #(
  parameter int unsigned WAKE_CYCLES      = seq_pkg::WAKE_CYCLES,
  parameter int unsigned LOWPWR_CYCLES    = seq_pkg::LOWPWR_CYCLES,
  parameter int unsigned PAUSE_CYCLES     = seq_pkg::PAUSE_CYCLES,
  parameter int unsigned OCP_SHORT_CYCLES = seq_pkg::OCP_SHORT_CYCLES,
  parameter int unsigned OCP_LONG_CYCLES  = seq_pkg::OCP_LONG_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  srst,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire seq_pkg::analog_flags_t analogFlags,
  input  wire seq_pkg::fast_faults_t  fastFaults,
  output logic                       generatorEnable,
  output logic                       regulatedSupplyEnable,
  output logic                       softStartEnable,
  output logic                       hvSourceEnable,
  output logic                       lowSideOn,
  output logic [2:0]                 stateCode,
  output logic                       irq
);

  localparam int TW = seq_pkg::TIMER_W;
  localparam int OW = seq_pkg::OCP_W;
  localparam int IW = seq_pkg::INT_W;

  localparam logic [TW-1:0] WAKE_LAST   = TW'(WAKE_CYCLES - 1);
  localparam logic [TW-1:0] BOOT_LAST   = TW'(seq_pkg::BOOT_CYCLES - 1);
  localparam logic [TW-1:0] PAUSE_LAST  = TW'(PAUSE_CYCLES - 1);
  localparam logic [TW-1:0] LOWPWR_LIM  = TW'(LOWPWR_CYCLES);
  localparam logic [OW-1:0] OCP_S_LIM   = OW'(OCP_SHORT_CYCLES);
  localparam logic [OW-1:0] OCP_L_LIM   = OW'(OCP_LONG_CYCLES);

  // Flag synchronisers
  logic [seq_pkg::FLAG_W-1:0] flagBits;
  seq_pkg::analog_flags_t     flags;

  flag_sync #(
    .W (seq_pkg::FLAG_W)
  ) u_flag_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .din     (analogFlags),
    .dout    (flagBits)
  );

  assign flags = seq_pkg::analog_flags_t'(flagBits);

  // State and timers
  seq_pkg::seq_state_t stateReg;
  seq_pkg::seq_state_t stateNext;
  logic [TW-1:0]       timerReg;
  logic [TW-1:0]       timerNext;
  logic [OW-1:0]       ocpShortCntReg;
  logic [OW-1:0]       ocpLongCntReg;
  seq_pkg::enables_t   enReg;
  seq_pkg::enables_t   enNext;

  // Register file
  logic [31:0]   ctrlReg;
  logic [IW-1:0] intStatusReg;
  logic [IW-1:0] intStatusNext;
  logic [IW-1:0] intMaskReg;
  logic [IW-1:0] intSet;
  logic [IW-1:0] intClr;
  logic [31:0]   prdataReg;
  logic          preadyReg;
  logic          pslverrReg;
  logic          irqReg;

  // Condition decode
  logic bulkReady;
  logic burstReady;
  logic ocpShortExpired;
  logic ocpLongExpired;
  logic fastFault;
  logic activeFault;
  logic startupFault;
  logic restartReq;
  logic swFault;
  logic wakeDone;
  logic bootDone;
  logic pauseDone;
  logic lowPwrTimeout;
  logic stateChange;

  assign swFault    = ctrlReg[seq_pkg::CTRL_SW_FAULT];
  assign bulkReady  = flags.bulkStartFlag
                    & ~flags.bulkStopFlag
                    & ~flags.bulkOvervoltageFlag
                    & ~flags.regulatedSupplyUndervoltage;
  assign burstReady = bulkReady
                    & ~flags.belowBurstThresholdFlag;

  assign ocpShortExpired = (ocpShortCntReg == OCP_S_LIM);
  assign ocpLongExpired  = (ocpLongCntReg == OCP_L_LIM);

  // Fast faults are already qualified by the generator, so no sync here
  assign fastFault = fastFaults.outputOvervoltageFault
                   | fastFaults.peakOvercurrentFault;

  assign activeFault = flags.overTemperatureFault
                     | flags.bulkOvervoltageFlag
                     | flags.bulkStopFlag
                     | fastFault
                     | ocpShortExpired
                     | ocpLongExpired
                     | flags.regulatedSupplyUndervoltage
                     | swFault;
  assign startupFault = flags.overTemperatureFault
                      | flags.bulkOvervoltageFlag;
  assign restartReq   = flags.supplyRestartFlag;

  assign wakeDone      = (timerReg >= WAKE_LAST);
  assign bootDone      = (timerReg >= BOOT_LAST);
  assign pauseDone     = (timerReg >= PAUSE_LAST);
  assign lowPwrTimeout = (timerReg >= LOWPWR_LIM);
  assign stateChange   = (stateNext != stateReg);

  // Next-state logic; faults take priority over restart and progress
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      seq_pkg::POWER_ON_START_STATE: begin
        if (flags.overTemperatureFault) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (flags.systemReady) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end
      end
      seq_pkg::HV_SOURCE_ON_STATE: begin
        if (startupFault) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (flags.startSwitchingFlag &&
                     !flags.supplyRestartFlag) begin
          stateNext = seq_pkg::HV_SOURCE_OFF_STATE;
        end
      end
      seq_pkg::HV_SOURCE_OFF_STATE: begin
        if (startupFault) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (restartReq) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end else if (bulkReady) begin
          stateNext = seq_pkg::ANALOG_WAKEUP_STATE;
        end
      end
      seq_pkg::ANALOG_WAKEUP_STATE: begin
        if (activeFault) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (restartReq) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end else if (wakeDone && burstReady) begin
          stateNext = seq_pkg::BOOT_CHARGE_STATE;
        end
      end
      seq_pkg::BOOT_CHARGE_STATE: begin
        if (activeFault) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (restartReq) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end else if (bootDone) begin
          stateNext = seq_pkg::NORMAL_RUN_STATE;
        end
      end
      seq_pkg::NORMAL_RUN_STATE: begin
        if (activeFault) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (restartReq) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end else if (flags.belowBurstThresholdFlag) begin
          stateNext = seq_pkg::LOW_POWER_RUN_STATE;
        end
      end
      seq_pkg::LOW_POWER_RUN_STATE: begin
        if (activeFault || lowPwrTimeout) begin
          stateNext = seq_pkg::FAULT_STATE;
        end else if (restartReq) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end else if (!flags.belowBurstThresholdFlag) begin
          stateNext = seq_pkg::NORMAL_RUN_STATE;
        end
      end
      seq_pkg::FAULT_STATE: begin
        if (pauseDone) begin
          stateNext = seq_pkg::HV_SOURCE_ON_STATE;
        end
      end
      default: begin
        stateNext = seq_pkg::POWER_ON_START_STATE;
      end
    endcase
  end

  // Dwell timer restarts on each state change
  assign timerNext = stateChange ? '0 :
                     ((&timerReg) ? timerReg : timerReg + TW'(1));

  // Enables follow the next state so they change with the state register
  always_comb begin
    enNext = '0;
    case (stateNext)
      seq_pkg::POWER_ON_START_STATE: begin
        enNext.hvSourceEnable = 1'b1;
      end
      seq_pkg::HV_SOURCE_ON_STATE: begin
        enNext.hvSourceEnable = 1'b1;
      end
      seq_pkg::HV_SOURCE_OFF_STATE,
      seq_pkg::ANALOG_WAKEUP_STATE: begin
        enNext.regulatedSupplyEnable = 1'b1;
      end
      seq_pkg::BOOT_CHARGE_STATE: begin
        enNext.regulatedSupplyEnable = 1'b1;
        enNext.lowSideOn             = 1'b1;
      end
      seq_pkg::NORMAL_RUN_STATE,
      seq_pkg::LOW_POWER_RUN_STATE: begin
        enNext.generatorEnable       = 1'b1;
        enNext.regulatedSupplyEnable = 1'b1;
        enNext.softStartEnable       = 1'b1;
      end
      seq_pkg::FAULT_STATE: begin
        enNext = '0;
      end
      default: begin
        enNext = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stateReg <= seq_pkg::POWER_ON_START_STATE;
      timerReg <= '0;
      enReg    <= '{hvSourceEnable: 1'b1, default: 1'b0};
    end else begin
      stateReg <= stateNext;
      timerReg <= timerNext;
      enReg    <= enNext;
    end
  end

  // Average overcurrent qualifiers: count while raw flag holds, saturate
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ocpShortCntReg <= '0;
      ocpLongCntReg  <= '0;
    end else begin
      if (!flags.avgOvercurrentShortRaw) begin
        ocpShortCntReg <= '0;
      end else if (!ocpShortExpired) begin
        ocpShortCntReg <= ocpShortCntReg + OW'(1);
      end
      if (!flags.avgOvercurrentLongRaw) begin
        ocpLongCntReg <= '0;
      end else if (!ocpLongExpired) begin
        ocpLongCntReg <= ocpLongCntReg + OW'(1);
      end
    end
  end

  // APB slave: one wait state, writes land on the completing edge
  logic        apbAccess;
  logic        apbDone;
  logic        wrStrobe;
  logic        hitCtrl;
  logic        hitStatus;
  logic        hitIntStatus;
  logic        hitIntMask;
  logic        addrHit;
  logic [31:0] statusWord;
  logic [31:0] readMux;

  assign apbAccess    = psel & penable & ~preadyReg;
  assign apbDone      = psel & penable & preadyReg;
  assign wrStrobe     = apbDone & pwrite & ~pslverrReg;
  assign hitCtrl      = (paddr == seq_pkg::ADDR_CTRL);
  assign hitStatus    = (paddr == seq_pkg::ADDR_STATUS);
  assign hitIntStatus = (paddr == seq_pkg::ADDR_INT_STATUS);
  assign hitIntMask   = (paddr == seq_pkg::ADDR_INT_MASK);
  assign addrHit      = hitCtrl | hitStatus | hitIntStatus | hitIntMask;

  assign statusWord = {8'h00,
                       fastFaults,
                       ocpLongExpired,
                       ocpShortExpired,
                       1'b0,
                       flags,
                       5'h00,
                       stateReg};

  assign readMux = hitCtrl      ? ctrlReg :
                   hitStatus    ? statusWord :
                   hitIntStatus ? {28'h0000000, intStatusReg} :
                   hitIntMask   ? {28'h0000000, intMaskReg} :
                   32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg  <= '0;
    end else begin
      preadyReg  <= apbAccess;
      pslverrReg <= apbAccess & ~addrHit;
      if (apbAccess) begin
        prdataReg <= pwrite ? 32'h0000_0000 : readMux;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrlReg    <= seq_pkg::CTRL_RESET;
      intMaskReg <= seq_pkg::INT_MASK_RESET;
    end else if (wrStrobe) begin
      if (hitCtrl) begin
        ctrlReg <= {31'h00000000, pwdata[seq_pkg::CTRL_SW_FAULT]};
      end
      if (hitIntMask) begin
        intMaskReg <= pwdata[IW-1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    intSet = '0;
    if (stateChange) begin
      intSet[seq_pkg::INT_FAULT]   =
        (stateNext == seq_pkg::FAULT_STATE);
      intSet[seq_pkg::INT_RESTART] =
        (stateNext == seq_pkg::HV_SOURCE_ON_STATE);
      intSet[seq_pkg::INT_RUN]     =
        (stateNext == seq_pkg::NORMAL_RUN_STATE);
      intSet[seq_pkg::INT_LOWPWR]  =
        (stateNext == seq_pkg::LOW_POWER_RUN_STATE);
    end
  end

  assign intClr        = (wrStrobe && hitIntStatus) ? pwdata[IW-1:0] : '0;
  assign intStatusNext = (intStatusReg & ~intClr) | intSet;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      intStatusReg <= '0;
      irqReg       <= 1'b0;
    end else begin
      intStatusReg <= intStatusNext;
      irqReg       <= |(intStatusNext & intMaskReg);
    end
  end

  // Outputs
  assign prdata                = prdataReg;
  assign pready                = preadyReg;
  assign pslverr               = pslverrReg;
  assign generatorEnable       = enReg.generatorEnable;
  assign regulatedSupplyEnable = enReg.regulatedSupplyEnable;
  assign softStartEnable       = enReg.softStartEnable;
  assign hvSourceEnable        = enReg.hvSourceEnable;
  assign lowSideOn             = enReg.lowSideOn;
  assign stateCode             = stateReg;
  assign irq                   = irqReg;

endmodule : system_state_fault_sequencer
